// File: pkg/fault_hmi_pkg.sv
// Constants, register map and carrier types of the fault and keypad link supervisor.
package fault_hmi_pkg;

	// Timebase: one second expressed in clock cycles.
	localparam int          CLK_PERIOD_NS     = 5;
	localparam int          SECOND_NS         = 1_000_000_000;
	localparam int          TICKS_PER_SEC_DEF = SECOND_NS / CLK_PERIOD_NS;
	localparam int          PRE_W             = 28;
	localparam int          SEC_W             = 10;

	// Supervision times in seconds.
	localparam logic [SEC_W-1:0] RECUR_WINDOW_S = 10'h01E;
	localparam logic [SEC_W-1:0] AR_DELAY_MIN   = 10'h003;
	localparam logic [SEC_W-1:0] AR_DELAY_MAX   = 10'h258;
	localparam logic [SEC_W-1:0] AR_DELAY_DEF   = 10'h003;
	localparam logic [SEC_W-1:0] LINK_LIM_MIN   = 10'h001;
	localparam logic [SEC_W-1:0] LINK_LIM_MAX   = 10'h3E7;
	localparam logic [SEC_W-1:0] LINK_LIM_DEF   = 10'h003;
	localparam logic [SEC_W-1:0] SEC_SATURATE   = 10'h3FF;

	// Recurrence counting.
	localparam int         RECUR_W          = 2;
	localparam logic [1:0] RECUR_LOCK_COUNT = 2'h3;
	localparam logic [1:0] RECUR_ONE        = 2'h1;

	// Fault identification.
	localparam int         CODE_W          = 8;
	localparam logic [7:0] LINK_FAULT_CODE = 8'h7F;

	// Register map, byte addresses.
	localparam int         ADDR_W          = 8;
	localparam logic [7:0] ADDR_CONFIG     = 8'h00;
	localparam logic [7:0] ADDR_AR_DELAY   = 8'h04;
	localparam logic [7:0] ADDR_LINK_LIMIT = 8'h08;
	localparam logic [7:0] ADDR_STATUS     = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK   = 8'h14;
	localparam logic [7:0] ADDR_CONTROL    = 8'h18;

	// Field positions.
	localparam int CFG_EN_BIT     = 0;
	localparam int CFG_MODE_LSB   = 4;
	localparam int CFG_ACTION_LSB = 8;
	localparam int CTRL_CLEAR_BIT = 0;
	localparam int STAT_FAULT     = 0;
	localparam int STAT_LOCKED    = 1;
	localparam int STAT_LINK_FLT  = 2;
	localparam int STAT_LINK_ALM  = 3;
	localparam int STAT_TIMED_OUT = 4;
	localparam int STAT_RECUR_LSB = 8;
	localparam int STAT_STATE_LSB = 12;

	// Interrupt status bits.
	localparam int IRQ_W         = 4;
	localparam int IRQ_AUTORESET = 0;
	localparam int IRQ_LOCKOUT   = 1;
	localparam int IRQ_LINK_FLT  = 2;
	localparam int IRQ_LINK_ALM  = 3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		LINK_OFF   = 2'b00,
		LINK_FAULT = 2'b01,
		LINK_ALARM = 2'b10
	} link_timeout_mode_type;

	typedef enum logic [2:0] {
		ACT_INDICATE  = 3'b000,
		ACT_RAMP_STOP = 3'b001,
		ACT_COAST     = 3'b010,
		ACT_LOCAL     = 3'b011,
		ACT_REMOTE    = 3'b100
	} link_alarm_action_type;

	typedef enum logic [1:0] {
		AR_IDLE   = 2'b00,
		AR_DELAY  = 2'b01,
		AR_WATCH  = 2'b10,
		AR_LOCKED = 2'b11
	} ar_state_type;

	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} axi_req_type;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_rsp_type;

	typedef struct packed {
		logic faultIndicated;
		logic motorDisable;
		logic rampStop;
		logic generalDisable;
		logic localControl;
		logic remoteControl;
	} motor_cmd_type;

endpackage : fault_hmi_pkg

// File: core/fault_hmi_supervisor.sv
// Fault auto-reset sequencer and keypad link watchdog with an AXI4-Lite register slave.
//
// Function
// [R1] Auto-reset enable bit, reset value off.
// [R2] Clear fault after programmable delay from occurrence.
// [R3] Three consecutive recurrences inhibit further auto-resets.
// [R4] Recurrence counts only within thirty seconds.
// [R5] Lockout holds fault and disable until power cycle.
// [R6] Link timeout mode: none, fault, alarm; default alarm.
// [R7] Alarm action: indicate, ramp, coast, local, remote.
// [R8] Timeout when silent longer than programmable limit.
// [R9] Keypad sends three telegrams every second.
// [R10] Settings writes ignored while motor runs; link limit writes are still taken.
// [R11] Telegram restarts counter; link fault stays latched.
`timescale 1ns/100ps
`default_nettype none

module fault_hmi_supervisor
	import fault_hmi_pkg::*;
#(
	parameter logic [fault_hmi_pkg::PRE_W-1:0] TICKS_PER_SEC =
		fault_hmi_pkg::PRE_W'(fault_hmi_pkg::TICKS_PER_SEC_DEF)
) (
	input  wire logic                            clk,
	input  wire logic                            sys_rst,
	input  wire fault_hmi_pkg::axi_req_type      axiReq,
	output var  fault_hmi_pkg::axi_rsp_type      axiRsp,
	input  wire logic                            faultIn,
	input  wire logic [fault_hmi_pkg::CODE_W-1:0] faultCode,
	input  wire logic                            telegramValid,
	input  wire logic                            motorRunning,
	output logic                                 faultReset,
	output var  fault_hmi_pkg::motor_cmd_type    motorCmd,
	output logic                                 keypadLinkFault,
	output logic                                 keypadLinkAlarm,
	output logic                                 irq
);
	import fault_hmi_pkg::*;

	typedef struct packed {
		logic [PRE_W-1:0] pre;
		logic [SEC_W-1:0] sec;
	} timer_type;

	typedef struct packed {
		logic                  awHave;
		logic                  wHave;
		logic [ADDR_W-1:0]     awAddr;
		logic [31:0]           wData;
		logic [3:0]            wStrb;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [31:0]           rdata;
		logic [1:0]            rresp;
		logic                  arEnable;
		link_timeout_mode_type linkMode;
		link_alarm_action_type linkAction;
		logic [SEC_W-1:0]      arDelay;
		logic [SEC_W-1:0]      linkLimit;
		logic [IRQ_W-1:0]      irqStatus;
		logic [IRQ_W-1:0]      irqMask;
		ar_state_type          arState;
		timer_type             arTimer;
		logic [RECUR_W-1:0]    recurCount;
		logic [CODE_W-1:0]     lastCode;
		logic                  faultSeen;
		timer_type             linkTimer;
		logic                  linkTimedOut;
		logic                  linkFault;
		logic                  linkAlarm;
		logic                  faultReset;
		motor_cmd_type         motorCmd;
	} state_type;

	state_type q;
	state_type d;

	// Counts cycles into whole seconds; the seconds field saturates instead of wrapping.
	function automatic timer_type advance(input timer_type t);
		timer_type r;
		r = t;
		if (t.pre == TICKS_PER_SEC - PRE_W'(1)) begin
			r.pre = '0;
			if (t.sec != SEC_SATURATE) begin
				r.sec = t.sec + SEC_W'(1);
			end
		end else begin
			r.pre = t.pre + PRE_W'(1);
		end
		return r;
	endfunction : advance

	function automatic logic [31:0] mergeStrobe(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return r;
	endfunction : mergeStrobe

	logic                  faultNow;
	logic [CODE_W-1:0]     codeNow;
	logic                  faultRise;
	logic [IRQ_W-1:0]      irqSet;
	logic [IRQ_W-1:0]      irqClr;
	logic                  doWrite;
	logic [31:0]           wrOld;
	logic [31:0]           wrVal;
	logic                  wrHit;
	logic                  manualClear;
	logic [31:0]           rdVal;
	logic                  rdHit;
	logic [SEC_W-1:0]      wrSec;
	link_timeout_mode_type wrMode;
	link_alarm_action_type wrAction;

	always_comb begin
		d = q;
		d.faultReset = 1'b0;
		irqSet = '0;
		irqClr = '0;
		manualClear = 1'b0;

		// The link fault joins the external faults so that auto-reset treats it alike.
		faultNow = faultIn | q.linkFault;
		codeNow = q.linkFault ? LINK_FAULT_CODE : faultCode;
		faultRise = faultNow & ~q.faultSeen;
		d.faultSeen = faultNow;

		// Register read path, decoded from the current state.
		rdVal = '0;
		rdHit = 1'b1;
		case (axiReq.araddr)
			ADDR_CONFIG: begin
				rdVal[CFG_EN_BIT] = q.arEnable;
				rdVal[CFG_MODE_LSB +: 2] = q.linkMode;
				rdVal[CFG_ACTION_LSB +: 3] = q.linkAction;
			end
			ADDR_AR_DELAY: begin
				rdVal[SEC_W-1:0] = q.arDelay;
			end
			ADDR_LINK_LIMIT: begin
				rdVal[SEC_W-1:0] = q.linkLimit;
			end
			ADDR_STATUS: begin
				rdVal[STAT_FAULT] = q.motorCmd.faultIndicated;
				rdVal[STAT_LOCKED] = (q.arState == AR_LOCKED);
				rdVal[STAT_LINK_FLT] = q.linkFault;
				rdVal[STAT_LINK_ALM] = q.linkAlarm;
				rdVal[STAT_TIMED_OUT] = q.linkTimedOut;
				rdVal[STAT_RECUR_LSB +: RECUR_W] = q.recurCount;
				rdVal[STAT_STATE_LSB +: 2] = q.arState;
			end
			ADDR_IRQ_STATUS: begin
				rdVal[IRQ_W-1:0] = q.irqStatus;
			end
			ADDR_IRQ_MASK: begin
				rdVal[IRQ_W-1:0] = q.irqMask;
			end
			ADDR_CONTROL: begin
				rdVal = '0;
			end
			default: begin
				rdHit = 1'b0;
			end
		endcase

		if (q.rvalid && axiReq.rready) begin
			d.rvalid = 1'b0;
		end
		if (!q.rvalid && axiReq.arvalid) begin
			d.rvalid = 1'b1;
			d.rdata = rdVal;
			d.rresp = rdHit ? RESP_OKAY : RESP_SLVERR;
		end

		// Write path: address and data are caught in either order, executed once both are in.
		if (q.bvalid && axiReq.bready) begin
			d.bvalid = 1'b0;
		end
		if (!q.awHave && !q.bvalid && axiReq.awvalid) begin
			d.awHave = 1'b1;
			d.awAddr = axiReq.awaddr;
		end
		if (!q.wHave && !q.bvalid && axiReq.wvalid) begin
			d.wHave = 1'b1;
			d.wData = axiReq.wdata;
			d.wStrb = axiReq.wstrb;
		end
		doWrite = q.awHave && q.wHave && !q.bvalid;
		wrOld = '0;
		wrHit = 1'b1;
		case (q.awAddr)
			ADDR_CONFIG: begin
				wrOld[CFG_EN_BIT] = q.arEnable;
				wrOld[CFG_MODE_LSB +: 2] = q.linkMode;
				wrOld[CFG_ACTION_LSB +: 3] = q.linkAction;
			end
			ADDR_AR_DELAY: wrOld[SEC_W-1:0] = q.arDelay;
			ADDR_LINK_LIMIT: wrOld[SEC_W-1:0] = q.linkLimit;
			ADDR_STATUS: wrOld = '0;
			ADDR_IRQ_STATUS: wrOld = '0;
			ADDR_IRQ_MASK: wrOld[IRQ_W-1:0] = q.irqMask;
			ADDR_CONTROL: wrOld = '0;
			default: wrHit = 1'b0;
		endcase
		wrVal = mergeStrobe(wrOld, q.wData, q.wStrb);
		wrSec = wrVal[SEC_W-1:0];
		wrMode = link_timeout_mode_type'(wrVal[CFG_MODE_LSB +: 2]);
		wrAction = link_alarm_action_type'(wrVal[CFG_ACTION_LSB +: 3]);
		if (doWrite) begin
			d.awHave = 1'b0;
			d.wHave = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = wrHit ? RESP_OKAY : RESP_SLVERR;
			case (q.awAddr)
				ADDR_CONFIG: begin
					// Settings that change the protection are frozen while the motor turns.
					if (!motorRunning) begin // [R10]
						d.arEnable = wrVal[CFG_EN_BIT]; // [R1]
						if (wrMode <= LINK_ALARM) begin
							d.linkMode = wrMode; // [R6]
						end
						if (wrAction <= ACT_REMOTE) begin
							d.linkAction = wrAction; // [R7]
						end
					end
				end
				ADDR_AR_DELAY: begin
					if (!motorRunning && wrSec >= AR_DELAY_MIN && wrSec <= AR_DELAY_MAX) begin // [R10]
						d.arDelay = wrSec; // [R2]
					end
				end
				ADDR_LINK_LIMIT: begin
					if (wrSec >= LINK_LIM_MIN && wrSec <= LINK_LIM_MAX) begin
						d.linkLimit = wrSec; // [R8]
					end
				end
				ADDR_IRQ_STATUS: irqClr = wrVal[IRQ_W-1:0];
				ADDR_IRQ_MASK: d.irqMask = wrVal[IRQ_W-1:0];
				ADDR_CONTROL: manualClear = wrVal[CTRL_CLEAR_BIT];
				default: begin
				end
			endcase
		end

		// Auto-reset sequencer.
		case (q.arState)
			AR_IDLE: begin
				d.recurCount = '0;
				if (faultRise && q.arEnable) begin // [R1]
					d.arState = AR_DELAY;
					d.arTimer = '0; // [R2]
					d.lastCode = codeNow;
				end
			end
			AR_DELAY: begin
				d.arTimer = advance(q.arTimer);
				if (!q.arEnable || !faultNow) begin
					d.arState = AR_IDLE;
				end else if (q.arTimer.sec >= q.arDelay) begin // [R2]
					// The fault stays seen until its source lets go, so no false recurrence follows.
					d.faultReset = 1'b1;
					d.arState = AR_WATCH;
					d.arTimer = '0;
					irqSet[IRQ_AUTORESET] = 1'b1;
				end
			end
			AR_WATCH: begin
				d.arTimer = advance(q.arTimer);
				if (!q.arEnable) begin
					d.arState = AR_IDLE;
				end else if (faultRise) begin
					d.arTimer = '0;
					d.lastCode = codeNow;
					if (codeNow == q.lastCode && q.arTimer.sec < RECUR_WINDOW_S) begin // [R4]
						d.recurCount = q.recurCount + RECUR_ONE; // [R3]
						if (q.recurCount + RECUR_ONE == RECUR_LOCK_COUNT) begin // [R3]
							d.arState = AR_LOCKED;
							irqSet[IRQ_LOCKOUT] = 1'b1;
						end else begin
							d.arState = AR_DELAY;
						end
					end else begin
						d.recurCount = '0;
						d.arState = AR_DELAY;
					end
				end else if (q.arTimer.sec >= RECUR_WINDOW_S) begin // [R4]
					d.arState = AR_IDLE;
				end
			end
			AR_LOCKED: begin
				// Only sys_rst leaves this state; no write or telegram releases it.
				d.arState = AR_LOCKED; // [R5]
			end
			default: begin
				d.arState = AR_IDLE;
			end
		endcase

		// Keypad link watchdog.
		if (telegramValid || d.faultReset) begin
			d.linkTimer = '0; // [R11]
			d.linkTimedOut = 1'b0;
		end else begin
			d.linkTimer = advance(q.linkTimer);
			if (q.linkTimer.sec > q.linkLimit ||
					(q.linkTimer.sec == q.linkLimit && q.linkTimer.pre != '0)) begin // [R8]
				d.linkTimedOut = 1'b1;
			end
		end
		if (d.faultReset || manualClear) begin
			d.linkFault = 1'b0;
		end
		if (d.linkTimedOut && !q.linkTimedOut && q.linkMode == LINK_FAULT) begin // [R6]
			d.linkFault = 1'b1; // [R11]
			irqSet[IRQ_LINK_FLT] = 1'b1;
		end
		d.linkAlarm = d.linkTimedOut && (q.linkMode == LINK_ALARM); // [R6]
		if (d.linkAlarm && !q.linkAlarm) begin
			irqSet[IRQ_LINK_ALM] = 1'b1;
		end

		// A new event wins over a clear written in the same cycle.
		d.irqStatus = (q.irqStatus & ~irqClr) | irqSet;

		d.motorCmd.faultIndicated = (d.arState == AR_LOCKED) | d.linkFault | faultIn; // [R5]
		d.motorCmd.motorDisable = (d.arState == AR_LOCKED) | d.linkFault; // [R5]
		d.motorCmd.rampStop = d.linkAlarm && (q.linkAction == ACT_RAMP_STOP); // [R7]
		d.motorCmd.generalDisable = d.linkAlarm && (q.linkAction == ACT_COAST); // [R7]
		d.motorCmd.localControl = d.linkAlarm && (q.linkAction == ACT_LOCAL); // [R7]
		d.motorCmd.remoteControl = d.linkAlarm && (q.linkAction == ACT_REMOTE); // [R7]
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '0;
			q.bresp <= RESP_OKAY;
			q.rresp <= RESP_OKAY;
			q.arEnable <= 1'b0; // [R1]
			q.linkMode <= LINK_ALARM; // [R6]
			q.linkAction <= ACT_RAMP_STOP; // [R7]
			q.arDelay <= AR_DELAY_DEF; // [R2]
			q.linkLimit <= LINK_LIM_DEF; // [R8]
			q.arState <= AR_IDLE;
		end else begin
			q <= d;
		end
	end

	// Handshake readies are combinational from state; data comes from flip-flops.
	always_comb begin
		axiRsp.awready = !q.awHave && !q.bvalid;
		axiRsp.wready = !q.wHave && !q.bvalid;
		axiRsp.bvalid = q.bvalid;
		axiRsp.bresp = q.bresp;
		axiRsp.arready = !q.rvalid;
		axiRsp.rvalid = q.rvalid;
		axiRsp.rdata = q.rdata;
		axiRsp.rresp = q.rresp;
	end

	assign faultReset = q.faultReset;
	assign motorCmd = q.motorCmd;
	assign keypadLinkFault = q.linkFault;
	assign keypadLinkAlarm = q.linkAlarm;
	assign irq = |(q.irqStatus & q.irqMask);

endmodule : fault_hmi_supervisor

`default_nettype wire

// File: test/fault_hmi_properties.sv
// Port-level checks of the fault and keypad link supervisor.
`timescale 1ns/100ps
`default_nettype none
module fault_hmi_properties
	import fault_hmi_pkg::*;
#(
	parameter logic [PRE_W-1:0] TICKS_PER_SEC = 28'h000_000C
) (
	input wire logic                         clk,
	input wire logic                         sys_rst,
	input wire fault_hmi_pkg::axi_req_type   axiReq,
	input wire fault_hmi_pkg::axi_rsp_type   axiRsp,
	input wire logic                         faultIn,
	input wire logic [fault_hmi_pkg::CODE_W-1:0] faultCode,
	input wire logic                         telegramValid,
	input wire logic                         motorRunning,
	input wire logic                         faultReset,
	input wire fault_hmi_pkg::motor_cmd_type motorCmd,
	input wire logic                         keypadLinkFault,
	input wire logic                         keypadLinkAlarm,
	input wire logic                         irq
);
	localparam int T = int'(TICKS_PER_SEC);
	logic [15:0] silent_q;
	logic [15:0] age_q;
	logic        prev_q;
	logic        anyFault;
	logic        locked;
	assign anyFault = faultIn | keypadLinkFault;
	// Counters saturate so that long quiet spells never wrap into a false young age.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			silent_q <= '0;
			age_q <= '0;
			prev_q <= 1'b0;
		end else begin
			prev_q <= anyFault;
			silent_q <= telegramValid ? '0 : silent_q + {15'h0000, ~&silent_q};
			age_q <= (anyFault & ~prev_q) ? '0 : age_q + {15'h0000, ~&age_q};
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence wrTaken;
		axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
	endsequence
	sequence wrAnswer;
		##2 axiRsp.bvalid;
	endsequence
	sequence lockSeen;
		motorCmd.motorDisable && !keypadLinkFault && !$past(keypadLinkFault);
	endsequence
	a_write_answer: assert property (wrTaken |-> wrAnswer)
		else $error("write response missing");
	a_read_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
		else $error("read response missing");
	a_pulse_single: assert property (faultReset |=> !faultReset)
		else $error("reset pulse too long");
	a_delay_elapsed: assert property (faultReset |-> age_q >= 16'(3 * T - 2))
		else $error("reset before delay");
	a_fault_present: assert property (faultReset |-> $past(anyFault))
		else $error("reset without fault");
	a_lock_holds: assert property (lockSeen |=> motorCmd.motorDisable)
		else $error("lockout released");
	a_lock_silent: assert property (lockSeen |-> !faultReset)
		else $error("reset while locked");
	a_fault_shown: assert property (faultIn |=> motorCmd.faultIndicated)
		else $error("fault not indicated");
	a_action_single: assert property ($onehot0({motorCmd.rampStop, motorCmd.generalDisable,
		motorCmd.localControl, motorCmd.remoteControl})) else $error("several actions");
	a_action_gated: assert property (!keypadLinkAlarm && !$past(keypadLinkAlarm) |->
		!(motorCmd.rampStop || motorCmd.generalDisable)) else $error("action without alarm");
	a_alarm_silence: assert property ($rose(keypadLinkAlarm) |-> silent_q >= 16'(T))
		else $error("alarm while talking");
	a_telegram_clear: assert property (telegramValid |-> ##[1:2] !keypadLinkAlarm)
		else $error("alarm kept after telegram");
endmodule : fault_hmi_properties
`default_nettype wire

// File: test/keypad_link_model.sv
// Keypad unit model that sends telegrams at a steady rate while talking.
`timescale 1ns/100ps
`default_nettype none
module keypad_link_model #(
	parameter int PERIOD = 4
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic talk,
	output var  logic telegramValid
);
	int cnt;
	// Talk low models a lost link; the rate gives three telegrams a second.
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= 0;
			telegramValid <= 1'b0;
		end else begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			telegramValid <= talk && (cnt == PERIOD - 1);
		end
	end
endmodule : keypad_link_model
`default_nettype wire

// File: test/fault_autoreset_and_hmi_timeout_test.sv
// Self-checking bench of the fault and keypad link supervisor.
`timescale 1ns/100ps
`default_nettype none
module fault_autoreset_and_hmi_timeout_test;
	import fault_hmi_pkg::*;
	localparam int T = 12;
	logic          clk;
	logic          sys_rst;
	axi_req_type   axiReq;
	axi_rsp_type   axiRsp;
	logic          faultIn;
	logic [7:0]    faultCode;
	logic          motorRunning;
	logic          talk;
	logic          telegramValid;
	logic          faultReset;
	motor_cmd_type motorCmd;
	logic          keypadLinkFault;
	logic          keypadLinkAlarm;
	logic          irq;
	int            errorCnt;
	int            testsRun;
	int            seed;
	int            rm[3];
	fault_hmi_supervisor #(.TICKS_PER_SEC(PRE_W'(T))) fault_hmi_supervisor_inst (
		.clk(clk), .sys_rst(sys_rst), .axiReq(axiReq), .axiRsp(axiRsp), .faultIn(faultIn),
		.faultCode(faultCode), .telegramValid(telegramValid), .motorRunning(motorRunning),
		.faultReset(faultReset), .motorCmd(motorCmd), .keypadLinkFault(keypadLinkFault),
		.keypadLinkAlarm(keypadLinkAlarm), .irq(irq));
	keypad_link_model #(.PERIOD(T / 3)) keypad_link_model_inst (
		.clk(clk), .sys_rst(sys_rst), .talk(talk), .telegramValid(telegramValid));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			errorCnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic endSim();
		if (errorCnt == 0 && testsRun > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : endSim
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		axiReq <= {1'b1, a, 1'b1, d, 4'hF, 1'b1, 1'b0, 8'h00, 1'b0};
		do begin
			@(posedge clk);
			if (axiRsp.awready) axiReq.awvalid <= 1'b0;
			if (axiRsp.wready) axiReq.wvalid <= 1'b0;
		end while (axiRsp.bvalid !== 1'b1);
		axiReq.bready <= 1'b0;
		chk(axiRsp.bresp, a > ADDR_CONTROL ? RESP_SLVERR : RESP_OKAY);
		// Model of the settings: config and delay ignored while running; out-of-range values always ignored.
		if (a == ADDR_CONFIG && !motorRunning) begin
			rm[0][0] = d[0];
			if (d[5:4] != 2'h3) rm[0][5:4] = d[5:4];
			if (d[10:8] <= 3'h4) rm[0][10:8] = d[10:8];
		end
		if (a == ADDR_AR_DELAY && !motorRunning && d[9:0] >= AR_DELAY_MIN && d[9:0] <= AR_DELAY_MAX)
			rm[1] = d[9:0];
		if (a == ADDR_LINK_LIMIT && d[9:0] >= LINK_LIM_MIN && d[9:0] <= LINK_LIM_MAX)
			rm[2] = d[9:0];
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		axiReq.arvalid <= 1'b1;
		axiReq.araddr <= a;
		axiReq.rready <= 1'b1;
		do begin
			@(posedge clk);
			if (axiRsp.arready) axiReq.arvalid <= 1'b0;
		end while (axiRsp.rvalid !== 1'b1);
		d = axiRsp.rdata;
		axiReq.rready <= 1'b0;
		chk(axiRsp.rresp, a > ADDR_CONTROL ? RESP_SLVERR : RESP_OKAY);
	endtask : axr
	task automatic regs();
		logic [31:0] d;
		for (int i = 0; i < 3; i++) begin
			axr(8'(4 * i), d);
			chk(d, rm[i]);
		end
	endtask : regs
	task automatic waitSig(input int s, input int lim, output int n);
		n = 0;
		while (n < lim && (s == 0 ? faultReset : s == 1 ? keypadLinkAlarm : keypadLinkFault) !== 1'b1) begin
			@(posedge clk);
			n++;
		end
	endtask : waitSig
	task automatic occur(input bit expReset);
		int n;
		repeat (2 + $unsigned($random(seed)) % 40) @(posedge clk);
		faultIn <= 1'b1;
		waitSig(0, 3 * T + 8, n);
		chk(expReset ? (n >= 3 * T - 2 && n <= 3 * T + 4) : n == 3 * T + 8, 1);
		faultIn <= 1'b0;
	endtask : occur
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		repeat (6000) @(posedge clk);
		errorCnt++;
		endSim();
	end
	initial begin
		int n;
		int m;
		int a;
		logic [31:0] d;
		seed = 32'hf2dd;
		sys_rst = 1'b1;
		axiReq = '0;
		faultIn = 1'b0;
		faultCode = 8'h00;
		motorRunning = 1'b0;
		talk = 1'b1;
		rm = '{32'h0000_0120, 32'h0000_0003, 32'h0000_0003};
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		regs();
		axr(8'h1C, d);
		chk(d, 32'h0000_0000);
		axw(8'h1C, 32'h0000_0001);
		axw(ADDR_LINK_LIMIT, 32'h0000_0000);
		axw(ADDR_AR_DELAY, 32'h0000_0259);
		axw(ADDR_LINK_LIMIT, 32'h0000_0001);
		motorRunning <= 1'b1;
		repeat (3) axw(ADDR_CONFIG, $random(seed));
		axw(ADDR_AR_DELAY, 32'h0000_0005);
		motorRunning <= 1'b0;
		axw(ADDR_CONFIG, $random(seed));
		regs();
		// Five actions in alarm mode, then the off mode and the fault mode.
		for (int i = 0; i < 7; i++) begin
			m = i < 5 ? 2 : i - 5;
			a = i < 5 ? i : 1;
			axw(ADDR_CONFIG, {21'h00_0000, a[2:0], 2'h0, m[1:0], 4'h0});
			talk <= 1'b0;
			waitSig(m == 1 ? 2 : 1, 3 * T, n);
			chk(m == 0 ? n == 3 * T : n >= T - 4 && n <= T + 4, 1);
			chk({motorCmd.rampStop, motorCmd.generalDisable, motorCmd.localControl,
				motorCmd.remoteControl}, (m == 2 && a > 0) ? 4'h8 >> (a - 1) : 4'h0);
			chk(motorCmd.motorDisable, m == 1);
			talk <= 1'b1;
			repeat (8) @(posedge clk);
			chk(keypadLinkAlarm, 1'b0);
			chk(keypadLinkFault, m == 1);
		end
		axw(ADDR_CONTROL, 32'h0000_0001);
		repeat (2) @(posedge clk);
		chk(keypadLinkFault, 1'b0);
		axw(ADDR_CONFIG, 32'h0000_0001);
		faultCode <= 8'($random(seed));
		occur(1'b1);
		chk(irq, 1'b0);
		axw(ADDR_IRQ_MASK, 32'h0000_0001);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		axw(ADDR_IRQ_STATUS, 32'h0000_0001);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		// A late reappearance must start the count afresh.
		repeat (31 * T) @(posedge clk);
		repeat (3) occur(1'b1);
		occur(1'b0);
		repeat (40 * T) @(posedge clk);
		chk(motorCmd.motorDisable, 1'b1);
		chk(motorCmd.faultIndicated, 1'b1);
		axr(ADDR_STATUS, d);
		chk(d[1], 1'b1);
		chk(d[13:12], 2'h3);
		sys_rst <= 1'b1;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		rm = '{32'h0000_0120, 32'h0000_0003, 32'h0000_0003};
		@(posedge clk);
		chk(motorCmd.motorDisable, 1'b0);
		regs();
		endSim();
	end
endmodule : fault_autoreset_and_hmi_timeout_test
bind fault_hmi_supervisor fault_hmi_properties #(.TICKS_PER_SEC(TICKS_PER_SEC)) props_inst (
	.clk(clk), .sys_rst(sys_rst), .axiReq(axiReq), .axiRsp(axiRsp), .faultIn(faultIn),
	.faultCode(faultCode), .telegramValid(telegramValid), .motorRunning(motorRunning),
	.faultReset(faultReset), .motorCmd(motorCmd), .keypadLinkFault(keypadLinkFault),
	.keypadLinkAlarm(keypadLinkAlarm), .irq(irq));
`default_nettype wire
